// ### hw/cps_clock_sleep_ctrl.sv
`include "cps_cfg.svh"
`default_nettype none

// Contract
// (RQ1) Unlock sets only on clean key write
// (RQ2) Unlock clears after four cycles or divide write
// (RQ3) Rewriting unlock neither restarts nor clears it
// (RQ4) Divide code changes only while unlocked
// (RQ5) Codes 0 to 8 divide by two-power
// (RQ6) Reset divide code follows divide-by-eight fuse
// (RQ7) Any divide code accepted regardless of fuse
// (RQ8) One divided enable slows every synchronous domain
// (RQ9) Sleep only when instruction and permit bit
// (RQ10) Sleep kind codes select five modes
// (RQ11) Hold core four cycles after start-up
// (RQ12) Reset during sleep restarts from reset vector
// (RQ13) Sleep never alters register file or RAM
// (RQ14) Upper low-power bits read as zero
// (RQ15) Idle stops only processor and flash clocks
// (RQ16) ADC noise mode also stops I/O clock
// (RQ17) ADC noise mode wakes on listed sources only
// (RQ18) Power-down stops oscillator and generated clocks
// (RQ19) Power-down wakes on listed asynchronous sources only
// (RQ20) Power-down restart delay set by source fuses
// (RQ21) Power-save timer two wakes when enabled
// (RQ22) Power-save stops unused timer two clock
// (RQ23) Standby keeps oscillator, resumes after six cycles
// (RQ24) Divide change is glitch-free at period boundary
// (RQ25) Reserved sleep kind behaves as idle
module cps_clock_sleep_ctrl #(
	parameter logic [15:0] WAKE_XTAL_CYCLES = 16'h4000 // Crystal restart delay
) (
	input  wire logic                  core_clk,             // 100 MHz source clock
	input  wire logic                  sys_rst,              // Synchronous reset, high
	input  wire cps_pkg::cps_apb_req_s apb_req,              // APB request
	output cps_pkg::cps_apb_rsp_s      apb_rsp,              // APB answer
	input  wire logic                  sleep_instr,          // Core executes sleep
	input  wire logic                  divide_by_eight_fuse, // Fuse, static
	input  wire logic [3:0]            clock_source_fuses,   // Fuses, static
	input  wire logic                  timer2_async,         // Timer two on own oscillator
	input  wire logic [1:0]            timer_two_irq_mask,   // Compare, overflow enables
	input  wire logic                  global_irq_enable,    // Core flag
	input  wire cps_pkg::cps_wake_s    wake_in,              // Asynchronous wake sources
	output logic                       sys_tick,             // Divided clock enable
	output cps_pkg::cps_gates_s        gates,                // Domain enables
	output logic                       core_halt,            // Core held
	output logic                       resume_irq,           // Run handler, then resume
	output logic                       restart_vector        // Start at reset vector
);

	logic [3:0]          divsel;
	logic                unlock;
	logic [2:0]          unlock_cnt;
	logic [2:0]          sleep_kind;
	logic                permit;
	cps_pkg::cps_state_e st;
	cps_pkg::cps_state_e next_st;
	logic [2:0]          mode;
	logic [2:0]          next_mode;
	logic [2:0]          hold_cnt;
	logic [2:0]          next_hold;
	logic                vec;
	logic                next_vec;
	cps_pkg::cps_wake_s  wake_meta;
	cps_pkg::cps_wake_s  wake_sync;
	logic                timer_done;

	// Reserved kinds fall back to idle so no odd gating pattern occurs
	function automatic logic [2:0] eff_mode(input logic [2:0] k);
		logic ok;
		ok = (k == `CPS_MODE_IDLE) || (k == `CPS_MODE_ADCNR) || (k == `CPS_MODE_PDOWN) ||
		     (k == `CPS_MODE_PSAVE) || (k == `CPS_MODE_STANDBY); // [RQ10]
		eff_mode = ok ? k : `CPS_MODE_IDLE; // [RQ25]
	endfunction : eff_mode

	// Wake sources each mode listens to
	function automatic logic wake_ok(input logic [2:0] m, input cps_pkg::cps_wake_s w, input logic t2);
		logic base;
		base = w.wdt_irq | w.twi_match | w.ext_level | w.pin_change;
		unique case (m)
			`CPS_MODE_IDLE:    wake_ok = base | w.adc_done | t2 | w.spm_ready | w.ext_edge | w.other_io;
			`CPS_MODE_ADCNR:   wake_ok = base | w.adc_done | t2 | w.spm_ready; // [RQ17]
			`CPS_MODE_PDOWN:   wake_ok = base; // [RQ19]
			`CPS_MODE_PSAVE:   wake_ok = base | t2; // [RQ21]
			`CPS_MODE_STANDBY: wake_ok = base;
			default:           wake_ok = 1'b0;
		endcase
	endfunction : wake_ok

	// Restart delay before the hold; zero in idle and ADC noise mode
	function automatic logic [15:0] restart_len(input logic [2:0] m, input logic [3:0] f,
	                                            input logic [15:0] xtal);
		logic fast;
		fast = (f == `CPS_SRC_EXT) || (f == `CPS_SRC_RC) || (f == `CPS_SRC_LF);
		unique case (m)
			`CPS_MODE_PDOWN,
			`CPS_MODE_PSAVE:   restart_len = fast ? `CPS_RC_START_CYCLES : xtal; // [RQ20]
			`CPS_MODE_STANDBY: restart_len = `CPS_STANDBY_CYCLES; // [RQ23]
			default:           restart_len = 16'h0000;
		endcase
	endfunction : restart_len

	// Enables for a state and mode
	function automatic cps_pkg::cps_gates_s gates_for(input cps_pkg::cps_state_e s, input logic [2:0] m,
	                                                  input logic t2a);
		cps_pkg::cps_gates_s g;
		g = '1;
		g.timer_osc = t2a;
		if (s == cps_pkg::st_hold) begin
			g.cpu   = 1'b0;
			g.flash = 1'b0;
		end else if (s != cps_pkg::st_active) begin
			g = '0;
			unique case (m)
				`CPS_MODE_IDLE: begin
					g = '1; // [RQ15]
					g.cpu       = 1'b0;
					g.flash     = 1'b0;
					g.timer_osc = t2a;
				end
				`CPS_MODE_ADCNR: begin
					g.adc       = 1'b1; // [RQ16]
					g.asy       = 1'b1;
					g.main_osc  = 1'b1;
					g.timer_osc = t2a;
				end
				`CPS_MODE_PDOWN: g = '0; // [RQ18]
				`CPS_MODE_PSAVE: begin
					g.asy       = t2a; // [RQ22]
					g.timer_osc = t2a;
					g.main_osc  = ~t2a;
					g.t2_sync   = ~t2a;
				end
				`CPS_MODE_STANDBY: g.main_osc = 1'b1; // [RQ23]
				default: g = '0;
			endcase
			if (s == cps_pkg::st_restart) begin
				g.main_osc = 1'b1;
			end
		end
		gates_for = g;
	endfunction : gates_for

	// Bus decode; a write lands on the edge where pready is sampled high
	wire logic [11:0] addr      = apb_req.paddr;
	wire logic        acc_first = apb_req.psel & apb_req.penable & ~apb_rsp.pready;
	wire logic        acc_done  = apb_req.psel & apb_req.penable & apb_rsp.pready;
	wire logic        hit_pre   = (addr == `CPS_ADDR_PRESCALE);
	wire logic        hit_lp    = (addr == `CPS_ADDR_LOWPOWER);
	wire logic        hit_st    = (addr == `CPS_ADDR_STATUS);
	wire logic        mapped    = hit_pre | hit_lp | hit_st;
	wire logic        wr_pre    = acc_done & apb_req.pwrite & hit_pre;
	wire logic        wr_lp     = acc_done & apb_req.pwrite & hit_lp;
	wire logic [7:0]  wd        = apb_req.pwdata[7:0];
	wire logic        key       = (wd == `CPS_UNLOCK_KEY);
	wire logic [1:0]  st_idx    = 2'(st);
	wire logic [7:0]  rd_pre    = {unlock, 3'h0, divsel};
	wire logic [7:0]  rd_lp     = {4'h0, sleep_kind, permit}; // [RQ14]
	wire logic [7:0]  rd_st     = {1'b0, sys_tick, core_halt, mode, st_idx};
	wire logic [7:0]  rd_byte   = hit_pre ? rd_pre : (hit_lp ? rd_lp : (hit_st ? rd_st : 8'h00));

	// Answer registered: one wait state per access
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			apb_rsp <= '0;
		end else begin
			apb_rsp.pready <= acc_first;
			if (acc_first) begin
				apb_rsp.prdata  <= {24'h000000, rd_byte};
				apb_rsp.pslverr <= ~mapped;
			end
		end
	end

	// Unlock sequencing
	wire logic set_unlock = wr_pre & ~unlock & key; // [RQ1]
	wire logic write_div  = wr_pre & unlock & ~wd[`CPS_UNLOCK_BIT]; // [RQ4]
	wire logic expire     = unlock & (unlock_cnt == 3'h1);

	// A key rewrite while open falls through to the countdown untouched
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			unlock     <= 1'b0;
			unlock_cnt <= 3'h0;
			divsel     <= divide_by_eight_fuse ? `CPS_DIV_RST_FUSED : `CPS_DIV_RST_PLAIN; // [RQ6]
		end else if (set_unlock) begin
			unlock     <= 1'b1;
			unlock_cnt <= `CPS_UNLOCK_CYCLES;
		end else if (write_div) begin
			divsel     <= wd[3:0]; // [RQ7]
			unlock     <= 1'b0; // [RQ2]
			unlock_cnt <= 3'h0;
		end else if (unlock) begin
			unlock_cnt <= unlock_cnt - 3'h1; // [RQ3]
			if (expire) begin
				unlock <= 1'b0; // [RQ2]
			end
		end
	end

	// Low-power control
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			sleep_kind <= `CPS_MODE_IDLE;
			permit     <= 1'b0;
		end else if (wr_lp) begin
			sleep_kind <= wd[3:1];
			permit     <= wd[0];
		end
	end

	// Wake pins come from stopped or foreign clocks
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			wake_meta <= '0;
			wake_sync <= '0;
		end else begin
			wake_meta <= wake_in;
			wake_sync <= wake_meta;
		end
	end

	// Divided enable shared by every synchronous domain
	cps_divider u_divider (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.divsel   (divsel),
		.tick     (sys_tick) // [RQ8]
	);

	// Wake qualification
	wire logic        t2_irq      = global_irq_enable & ((wake_sync.t2_ovf & timer_two_irq_mask[0]) |
	                                                     (wake_sync.t2_cmp & timer_two_irq_mask[1])); // [RQ21]
	wire logic        wake_hit    = wake_ok(mode, wake_sync, t2_irq);
	wire logic [15:0] rlen        = restart_len(mode, clock_source_fuses, WAKE_XTAL_CYCLES);
	wire logic        in_sleep    = (st == cps_pkg::st_sleep);
	wire logic        leave_sleep = in_sleep & (wake_sync.sys_reset | wake_hit); // [RQ12]
	wire logic        timer_start = leave_sleep & (rlen != 16'h0000);

	cps_wake_timer u_wake_timer (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.start    (timer_start),
		.length   (rlen),
		.done     (timer_done)
	);

	// Sleep sequence
	always_comb begin
		next_st   = st;
		next_mode = mode;
		next_vec  = vec;
		next_hold = `CPS_HOLD_LAST;
		unique case (st)
			cps_pkg::st_active: begin
				if (sleep_instr & permit) begin
					next_st   = cps_pkg::st_sleep; // [RQ9]
					next_mode = eff_mode(sleep_kind);
					next_vec  = 1'b0;
				end
			end
			cps_pkg::st_sleep: begin
				if (leave_sleep) begin
					next_vec = wake_sync.sys_reset; // [RQ12]
					next_st  = (rlen == 16'h0000) ? cps_pkg::st_hold : cps_pkg::st_restart;
				end
			end
			cps_pkg::st_restart: begin
				next_vec = vec | wake_sync.sys_reset;
				if (timer_done) begin
					next_st = cps_pkg::st_hold;
				end
			end
			cps_pkg::st_hold: begin
				next_vec = vec | wake_sync.sys_reset;
				if (hold_cnt == 3'h0) begin
					next_st = cps_pkg::st_active;
				end else begin
					next_hold = hold_cnt - 3'h1; // [RQ11]
				end
			end
		endcase
	end

	wire logic hold_end = (st == cps_pkg::st_hold) & (hold_cnt == 3'h0);

	// Memories keep contents: only enables drop, nothing is cleared
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			st             <= cps_pkg::st_active;
			mode           <= `CPS_MODE_IDLE;
			hold_cnt       <= `CPS_HOLD_LAST;
			vec            <= 1'b0;
			core_halt      <= 1'b0;
			resume_irq     <= 1'b0;
			restart_vector <= 1'b0;
			gates          <= '1;
		end else begin
			st             <= next_st;
			mode           <= next_mode;
			hold_cnt       <= next_hold;
			vec            <= next_vec;
			core_halt      <= (next_st != cps_pkg::st_active);
			resume_irq     <= hold_end & ~next_vec; // [RQ11]
			restart_vector <= hold_end & next_vec; // [RQ12]
			gates          <= gates_for(next_st, next_mode, timer2_async); // [RQ13]
		end
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	a_unlock_key_only: assert property ( // [RQ1]
		$rose(unlock) |-> $past(wr_pre && (wd == `CPS_UNLOCK_KEY)))
		else $error("unlock set without clean key write");

	a_unlock_expires: assert property ( // [RQ2]
		$rose(unlock) |-> ##[1:4] !unlock)
		else $error("unlock window longer than four cycles");

	a_unlock_no_extend: assert property ( // [RQ3]
		(unlock && (unlock_cnt > 3'h1) && wr_pre && key) |=> (unlock && (unlock_cnt == $past(unlock_cnt) - 3'h1)))
		else $error("key rewrite changed unlock window");

	a_divsel_guarded: assert property ( // [RQ4]
		!$stable(divsel) |-> $past(unlock))
		else $error("divide code changed while locked");

	a_sleep_needs_permit: assert property ( // [RQ9]
		((st == cps_pkg::st_active) && sleep_instr && !permit) |=> (st == cps_pkg::st_active))
		else $error("slept without permit bit");

	a_idle_gates: assert property ( // [RQ15]
		(in_sleep && $past(in_sleep) && (mode == `CPS_MODE_IDLE)) |-> (!gates.cpu && !gates.flash && gates.io && gates.adc))
		else $error("idle gating wrong");

	a_pdown_gates: assert property ( // [RQ18]
		(in_sleep && (mode == `CPS_MODE_PDOWN)) |-> (!gates.main_osc && !gates.io && !gates.cpu && !gates.asy))
		else $error("power-down left a clock running");

	a_hold_four: assert property ( // [RQ11]
		$rose(st == cps_pkg::st_hold) |-> (st == cps_pkg::st_hold) [*4] ##1 (resume_irq || restart_vector))
		else $error("core hold not four cycles");

	a_standby_six: assert property ( // [RQ23]
		($rose(st == cps_pkg::st_restart) && (mode == `CPS_MODE_STANDBY)) |->
			(st == cps_pkg::st_restart) [*6] ##1 (st == cps_pkg::st_hold))
		else $error("standby restart not six cycles");

	a_reset_vector: assert property ( // [RQ12]
		(in_sleep && wake_sync.sys_reset && (mode == `CPS_MODE_IDLE)) |-> ##5 (restart_vector && !resume_irq))
		else $error("reset in sleep did not reach reset vector");

endmodule : cps_clock_sleep_ctrl

`default_nettype wire

// ### hw/cps_cfg.svh
`ifndef CPS_CFG_SVH
`define CPS_CFG_SVH

// Register byte addresses on the APB bus
`define CPS_ADDR_PRESCALE   12'h000
`define CPS_ADDR_LOWPOWER   12'h004
`define CPS_ADDR_STATUS     12'h008

// Prescale control fields
`define CPS_UNLOCK_BIT      7
`define CPS_UNLOCK_KEY      8'h80
`define CPS_UNLOCK_CYCLES   3'h4
`define CPS_DIV_RST_FUSED   4'h3
`define CPS_DIV_RST_PLAIN   4'h0
`define CPS_DIV_MAX         4'h8

// Sleep kind codes
`define CPS_MODE_IDLE       3'h0
`define CPS_MODE_ADCNR      3'h1
`define CPS_MODE_PDOWN      3'h2
`define CPS_MODE_PSAVE      3'h3
`define CPS_MODE_STANDBY    3'h6

// Clock source fuse codes that restart quickly
`define CPS_SRC_EXT         4'h0
`define CPS_SRC_RC          4'h2
`define CPS_SRC_LF          4'h3

// Wake timing in core_clk cycles
`define CPS_RC_START_CYCLES 16'h0006
`define CPS_STANDBY_CYCLES  16'h0006
`define CPS_HOLD_LAST       3'h3

`endif

// ### hw/cps_pkg.sv
`default_nettype none

package cps_pkg;

	// Sleep controller sequence
	typedef enum logic [1:0] {st_active, st_sleep, st_restart, st_hold} cps_state_e;

	// APB request from the master
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} cps_apb_req_s;

	// APB answer to the master
	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} cps_apb_rsp_s;

	// Clock domain and oscillator enables
	typedef struct packed {
		logic cpu;
		logic flash;
		logic io;
		logic adc;
		logic asy;
		logic main_osc;
		logic timer_osc;
		logic t2_sync;
	} cps_gates_s;

	// Wake and reset requests from peripherals and pins
	typedef struct packed {
		logic sys_reset;
		logic adc_done;
		logic wdt_irq;
		logic twi_match;
		logic t2_ovf;
		logic t2_cmp;
		logic spm_ready;
		logic ext_level;
		logic pin_change;
		logic ext_edge;
		logic other_io;
	} cps_wake_s;

endpackage : cps_pkg

`default_nettype wire

// ### hw/cps_divider.sv
`include "cps_cfg.svh"
`default_nettype none

module cps_divider (
	input  wire logic       core_clk, // Undivided source clock
	input  wire logic       sys_rst,  // Synchronous reset
	input  wire logic [3:0] divsel,   // Requested divide code
	output logic            tick      // System clock enable
);

	logic [7:0] cnt;
	logic [3:0] cur;

	// Terminal count for a code; reserved codes clamp to the slowest rate
	function automatic logic [7:0] last_count(input logic [3:0] sel);
		logic [3:0] s;
		s = (sel > `CPS_DIV_MAX) ? `CPS_DIV_MAX : sel;
		last_count = 8'((9'h001 << s) - 9'h001); // [RQ5]
	endfunction : last_count

	wire logic wrap = (cnt == last_count(cur));

	// New code only taken at a period boundary, so no short period appears
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			cnt  <= 8'h00;
			cur  <= 4'h0;
			tick <= 1'b0;
		end else begin
			tick <= wrap;
			if (wrap) begin
				cnt <= 8'h00;
				cur <= divsel; // [RQ24]
			end else begin
				cnt <= cnt + 8'h01;
			end
		end
	end

endmodule : cps_divider

`default_nettype wire

// ### hw/cps_wake_timer.sv
`default_nettype none

module cps_wake_timer (
	input  wire logic        core_clk, // Undivided source clock
	input  wire logic        sys_rst,  // Synchronous reset
	input  wire logic        start,    // Load a new delay
	input  wire logic [15:0] length,   // Delay in cycles, nonzero
	output logic             done      // High in the last delay cycle
);

	logic [15:0] cnt;

	assign done = (cnt == 16'h0001);

	// Counts down to zero and then rests
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			cnt <= 16'h0000;
		end else if (start) begin
			cnt <= length;
		end else if (cnt != 16'h0000) begin
			cnt <= cnt - 16'h0001;
		end
	end

endmodule : cps_wake_timer

`default_nettype wire

// ### verification/cps_core_model.sv
`include "cps_cfg.svh"
`default_nettype none

module cps_core_model (
	input  wire logic                  core_clk,    // Source clock
	input  wire cps_pkg::cps_apb_rsp_s apb_rsp,     // APB answer
	output var  cps_pkg::cps_apb_req_s apb_req,     // APB request
	output var  logic                  sleep_instr  // Sleep executed
);
	timeunit 1ns;
	timeprecision 1ps;

	// Quiet bus before the first transfer
	initial begin
		apb_req = '0;
		sleep_instr = 1'b0;
	end

	// One transfer; request stands after pready so a back-to-back setup can follow
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd,
		output logic er);
		apb_req <= '{1'b1, 1'b0, wr, a, d};
		@(posedge core_clk);
		apb_req.penable <= 1'b1;
		do @(posedge core_clk); while (apb_rsp.pready !== 1'b1);
		rd = apb_rsp.prdata;
		er = apb_rsp.pslverr;
	endtask : xfer

	// Release the bus for one cycle
	task automatic idle;
		apb_req <= '0;
		@(posedge core_clk);
	endtask : idle

	// Key then new code back to back, well inside the window
	task automatic set_div(input logic [3:0] code);
		logic [31:0] r;
		logic        e;
		xfer(1'b1, `CPS_ADDR_PRESCALE, 32'h0000_0080, r, e);
		xfer(1'b1, `CPS_ADDR_PRESCALE, {28'h0, code}, r, e);
		idle();
	endtask : set_div

	// Single-cycle sleep instruction
	task automatic pulse;
		sleep_instr <= 1'b1;
		@(posedge core_clk);
		sleep_instr <= 1'b0;
	endtask : pulse

	// Permit set just before sleeping
	task automatic doze(input logic [2:0] kind);
		logic [31:0] r;
		logic        e;
		xfer(1'b1, `CPS_ADDR_LOWPOWER, {28'h0, kind, 1'b1}, r, e);
		idle();
		pulse();
	endtask : doze
endmodule : cps_core_model

`default_nettype wire

// ### verification/cps_clock_sleep_ctrl_bench.sv
`include "cps_cfg.svh"
`default_nettype none

module cps_clock_sleep_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [15:0] XTAL = 16'h0008; // Short crystal restart keeps the run brief
	localparam int          BASE = 8;        // Edges from wake raise to first active sample

	logic                  core_clk, sys_rst, fuse8, t2a, gie, slp, tick, halt, rirq, rvec, er;
	logic [3:0]            srcf, code;
	logic [1:0]            t2m;
	logic [31:0]           rd;
	cps_pkg::cps_apb_req_s req;
	cps_pkg::cps_apb_rsp_s rsp;
	cps_pkg::cps_wake_s    wk;
	cps_pkg::cps_gates_s   g;
	int                    err_total, checked, seed, p, n;

	cps_clock_sleep_ctrl #(.WAKE_XTAL_CYCLES(XTAL)) uut (
		.core_clk(core_clk), .sys_rst(sys_rst), .apb_req(req), .apb_rsp(rsp), .sleep_instr(slp),
		.divide_by_eight_fuse(fuse8), .clock_source_fuses(srcf), .timer2_async(t2a),
		.timer_two_irq_mask(t2m), .global_irq_enable(gie), .wake_in(wk), .sys_tick(tick), .gates(g),
		.core_halt(halt), .resume_irq(rirq), .restart_vector(rvec));

	cps_core_model core (.core_clk(core_clk), .apb_rsp(rsp), .apb_req(req), .sleep_instr(slp));

	// Free-running source clock
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic finish_test;
		$display("errors=%0d checks=%0d", err_total, checked);
		if (err_total == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : finish_test

	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic eer);
		core.xfer(1'b0, a, 32'h0, rd, er);
		core.idle();
		chk(rd, exp);
		chk(er, eer);
	endtask : rdchk

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		core.xfer(1'b1, a, d, rd, er);
		core.idle();
	endtask : wr

	task automatic do_reset(input logic f);
		fuse8 <= f;
		sys_rst <= 1'b1;
		repeat (8) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(posedge core_clk);
	endtask : do_reset

	// Skip past any switch-over, then time one full tick period
	task automatic tick_period(output int per);
		repeat (3) do @(posedge core_clk); while (tick !== 1'b1);
		per = 0;
		do begin
			@(posedge core_clk);
			per++;
		end while (tick !== 1'b1 && per < 600);
	endtask : tick_period

	// Expected gates while asleep, cpu first and t2_sync last
	function automatic logic [7:0] exp_g(input int k, input logic a);
		case (k)
			1: return {6'b000111, a, 1'b0};
			2: return 8'h00;
			3: return {4'b0000, a, ~a, a, ~a};
			6: return 8'h04;
			default: return {6'b001111, a, 1'b1};
		endcase
	endfunction : exp_g

	function automatic int exp_len(input int k, input logic [3:0] f);
		if (k == 6)
			return 6;
		if (k == 2 || k == 3)
			return (f == 4'h0 || f == 4'h2 || f == 4'h3) ? 6 : int'(XTAL);
		return 0;
	endfunction : exp_len

	// Sources that must not wake the given kind; overflow stays masked
	function automatic logic [10:0] noise(input int k);
		case (k)
			1: return 11'h003;
			2, 3, 6: return 11'h252;
			default: return 11'h000;
		endcase
	endfunction : noise

	// Cut a hang short well past the expected run length
	initial begin
		repeat (40000) @(posedge core_clk);
		err_total++;
		finish_test();
	end

	// Main sequence
	initial begin
		seed = 32'hFED3;
		err_total = 0;
		checked = 0;
		sys_rst = 1'b1;
		fuse8 = 1'b1;
		t2a = 1'b0;
		gie = 1'b1;
		srcf = 4'h0;
		t2m = 2'h1;
		wk = '0;
		do_reset(1'b1);
		rdchk(`CPS_ADDR_PRESCALE, 32'h03, 1'b0);
		tick_period(p);
		chk(p, 8);
		wr(`CPS_ADDR_PRESCALE, 32'h01);
		wr(`CPS_ADDR_PRESCALE, 32'h81);
		rdchk(`CPS_ADDR_PRESCALE, 32'h03, 1'b0);
		core.xfer(1'b1, `CPS_ADDR_PRESCALE, 32'h80, rd, er);
		rdchk(`CPS_ADDR_PRESCALE, 32'h83, 1'b0);
		rdchk(`CPS_ADDR_PRESCALE, 32'h03, 1'b0);
		core.xfer(1'b1, `CPS_ADDR_PRESCALE, 32'h80, rd, er);
		core.xfer(1'b1, `CPS_ADDR_PRESCALE, 32'h80, rd, er);
		rdchk(`CPS_ADDR_PRESCALE, 32'h03, 1'b0);
		rdchk(12'h00C, 32'h0, 1'b1);
		wr(`CPS_ADDR_LOWPOWER, 32'hFF);
		rdchk(`CPS_ADDR_LOWPOWER, 32'h0F, 1'b0);
		wr(`CPS_ADDR_LOWPOWER, 32'h0E);
		core.pulse();
		repeat (4) @(posedge core_clk);
		chk(halt, 1'b0);
		// Every code, the last one a random reserved code
		for (int c = 0; c < 10; c++) begin
			code = (c == 9) ? 4'(9 + ({$random(seed)} % 7)) : 4'(c);
			core.set_div(code);
			rdchk(`CPS_ADDR_PRESCALE, {28'h0, code}, 1'b0);
			tick_period(p);
			chk(p, 1 << (code > 8 ? 8 : code));
		end
		// Every sleep kind, reserved ones too, with random fuses and timer clocking
		for (int k = 0; k < 8; k++) begin
			t2a <= 1'($random(seed));
			srcf <= 4'($random(seed));
			t2m <= 2'h2; // Compare enabled, overflow masked
			@(posedge core_clk);
			core.doze(3'(k));
			repeat (3) @(posedge core_clk);
			chk(halt, 1'b1);
			chk(g, exp_g(k, t2a));
			wk <= noise(k);
			repeat (12) @(posedge core_clk);
			chk(halt, 1'b1);
			wk <= (k == 3) ? 11'h020 : (k == 2 || k == 4) ? 11'h400 : 11'h004;
			n = 0;
			do begin
				@(posedge core_clk);
				n++;
			end while (halt !== 1'b0 && n < 100);
			chk(n, BASE + exp_len(k, srcf));
			chk({rirq, rvec}, (k == 2 || k == 4) ? 2'b01 : 2'b10);
			wk <= '0;
			wr(`CPS_ADDR_LOWPOWER, 32'h0);
		end
		do_reset(1'b0);
		rdchk(`CPS_ADDR_PRESCALE, 32'h00, 1'b0);
		tick_period(p);
		chk(p, 1);
		rdchk(`CPS_ADDR_STATUS, 32'h40, 1'b0);
		finish_test();
	end
endmodule : cps_clock_sleep_ctrl_bench

`default_nettype wire
